// File: verilog/dfpe_pkg.sv
// Constants and types shared by the feedback payload encoder
package dfpe_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int TX_PERIOD_MS = 1000;
  localparam int TX_PERIOD_CYC = TX_PERIOD_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PERIOD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_SAMPLE_BIT = 1;
  localparam int CTRL_EN_LSB = 4;
  localparam logic [7:0] CTRL_RST = 8'hf1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_PEND_BIT = 1;
  localparam int ST_FULL_BIT = 2;
  localparam int ST_FRAMES_LSB = 16;

  // ----------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_DISABLED = 8'h00;
  localparam logic [7:0] MODE_STOPPED = 8'h01;
  localparam logic [7:0] MODE_RUNNING = 8'h02;
  localparam logic [7:0] MODE_STEPPING = 8'h03;
  localparam logic [7:0] MODE_HOLDING = 8'h04;
  localparam logic [7:0] DIR_CCW = 8'h00;
  localparam logic [7:0] DIR_CW = 8'h01;
  localparam logic [15:0] FIELD_SAT = 16'hffff;

  // ----------------------------------------------------------------
  // Parameter groups (65360, 65392, 65365, 65397)
  // ----------------------------------------------------------------
  localparam logic [15:0] PGN_MOT1 = 16'hff50;
  localparam logic [15:0] PGN_MOT2 = 16'hff70;
  localparam logic [15:0] PGN_IO1 = 16'hff55;
  localparam logic [15:0] PGN_IO2 = 16'hff75;

  // ----------------------------------------------------------------
  // Field bit positions, byte 1 in bits 7:0, low byte first
  // ----------------------------------------------------------------
  localparam int MP_PH1 = 0;
  localparam int MP_PH2 = 16;
  localparam int MP_MODE = 32;
  localparam int MP_DIR = 40;
  localparam int MP_RATE = 48;
  localparam int IP_AN1 = 0;
  localparam int IP_FQ1 = 16;
  localparam int IP_AN2 = 32;
  localparam int IP_FQ2 = 48;
  localparam int OP_TGT = 0;
  localparam int OP_ENC = 16;
  localparam int OP_EDIR = 32;
  localparam int OP_VSUP = 40;
  localparam int OP_TEMP = 56;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic {FSM_IDLE, FSM_SEND} dfpe_fsm_e;

  typedef struct packed {
    logic wreq;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [31:0] period;
    logic [31:0] div;
    logic pend;
    dfpe_fsm_e fsm;
    logic [1:0] idx;
    logic [3:0][63:0] snap;
    logic [15:0] frames;
  } dfpe_top_s;

  typedef struct packed {
    logic hv;
    logic sv;
    logic [15:0] hp;
    logic [63:0] hd;
    logic [15:0] sp;
    logic [63:0] sd;
  } dfpe_buf_s;

endpackage

// File: verilog/dfpe_stream_if.sv
// Payload stream between the framer core and its output buffer
`timescale 1ns/1ps
interface dfpe_stream_if;
  logic valid;
  logic ready;
  logic [15:0] pgn;
  logic [63:0] data;
  modport src (output valid, output pgn, output data, input ready);
  modport snk (input valid, input pgn, input data, output ready);
endinterface

// File: verilog/dfpe_tx_buf.sv
// Two-entry output buffer, head and skid registers
`timescale 1ns/1ps
module dfpe_tx_buf (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Fill side
  dfpe_stream_if.snk in_if,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [15:0] out_pgn_out,
  output logic [63:0] out_data_out
);

  dfpe_pkg::dfpe_buf_s st_ff;
  dfpe_pkg::dfpe_buf_s nxt_st;

  // Ready falls once the skid entry is taken
  assign in_if.ready = ~st_ff.sv;
  assign out_valid_out = st_ff.hv;
  assign out_pgn_out = st_ff.hp;
  assign out_data_out = st_ff.hd;

  // Pop head, refill from skid, then accept new word
  always_comb begin
    nxt_st = st_ff;
    if (st_ff.hv && out_ready_in) begin
      if (st_ff.sv) begin
        nxt_st.hp = st_ff.sp;
        nxt_st.hd = st_ff.sd;
        nxt_st.sv = 1'b0;
      end else begin
        nxt_st.hv = 1'b0;
      end
    end
    if (in_if.valid && !st_ff.sv) begin
      if (!nxt_st.hv) begin
        nxt_st.hv = 1'b1;
        nxt_st.hp = in_if.pgn;
        nxt_st.hd = in_if.data;
      end else begin
        nxt_st.sv = 1'b1;
        nxt_st.sp = in_if.pgn;
        nxt_st.sd = in_if.data;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule // dfpe_tx_buf

// File: verilog/dfpe_motor_fmt.sv
// Formats one motor feedback payload from live drive values
`timescale 1ns/1ps
module dfpe_motor_fmt (
  // Phase currents, mA
  input wire logic [15:0] ph1_ma_in,
  input wire logic [15:0] ph2_ma_in,
  // Mode sources
  input wire logic [7:0] cmd_mode_in,
  input wire logic stepping_in,
  input wire logic holding_in,
  input wire logic estop_in,
  input wire logic fault_in,
  // Direction and rate sources
  input wire logic loop_sel_in,
  input wire logic cmd_dir_in,
  input wire logic loop_dir_in,
  input wire logic [15:0] cmd_rate_in,
  input wire logic [15:0] loop_rate_in,
  // Packed payload
  output logic [63:0] payload_out
);

  logic [7:0] mode;
  logic dir;

  // Resolve actual mode and direction, then pack low byte first
  always_comb begin
    mode = cmd_mode_in;
    if (estop_in || fault_in || cmd_mode_in == dfpe_pkg::MODE_DISABLED) begin
      mode = dfpe_pkg::MODE_DISABLED; // [R4]
    end else if (holding_in) begin
      mode = dfpe_pkg::MODE_HOLDING; // [R4]
    end else if (stepping_in) begin
      mode = dfpe_pkg::MODE_STEPPING; // [R4]
    end
    dir = loop_sel_in ? loop_dir_in : cmd_dir_in; // [R6]
    payload_out = '0;
    payload_out[dfpe_pkg::MP_PH1 +: 16] = ph1_ma_in; // [R1] [R2] [R17]
    payload_out[dfpe_pkg::MP_PH2 +: 16] = ph2_ma_in; // [R1] [R15]
    payload_out[dfpe_pkg::MP_MODE +: 8] = mode; // [R3]
    payload_out[dfpe_pkg::MP_DIR +: 8] = dir ? dfpe_pkg::DIR_CW
                                             : dfpe_pkg::DIR_CCW; // [R5]
    payload_out[dfpe_pkg::MP_RATE +: 16] =
      loop_sel_in ? loop_rate_in : cmd_rate_in; // [R7]
  end

endmodule // dfpe_motor_fmt

// File: verilog/dfpe_encoder_top.sv
// Feedback payload encoder: snapshot, framing, register slave
//
// Behaviour
// [R1] Phase current: two bytes, 1 mA per count
// [R2] Current is plain average, not RMS
// [R3] Mode byte codes 00 to 04
// [R4] Mode shows disabled, stepping, holding overrides
// [R5] Motor direction byte: 00 ccw, 01 cw
// [R6] CAN-commanded direction echoes commanded value; the loop direction is sent instead when loop select is set
// [R7] Step rate two bytes, echoes commanded rate; the loop rate is sent instead when loop select is set
// [R8] Analog input two bytes, 0.001 unit
// [R9] Frequency input two bytes, 0.1 unit
// [R10] Output target two bytes, 0.001 unit
// [R11] Encoder counter two bytes, one step
// [R12] Encoder direction byte: 00 ccw, 01 cw
// [R13] Supply voltage two bytes, 0.01 V
// [R14] Temperature one byte, 1 C
// [R15] Motor payload layout, groups 65360 and 65392
// [R16] Second I/O payload layout, group 65397
// [R17] Low byte first, unused bytes all ones
// [R18] All fields of a frame sampled together
`timescale 1ns/1ps
module dfpe_encoder_top #(
  parameter int unsigned PERIOD_CYC = dfpe_pkg::TX_PERIOD_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Motor values, index 0 is motor one
  input wire logic [1:0][15:0] mot_ph1_ma_in,
  input wire logic [1:0][15:0] mot_ph2_ma_in,
  input wire logic [1:0][7:0] mot_cmd_mode_in,
  input wire logic [1:0] mot_stepping_in,
  input wire logic [1:0] mot_holding_in,
  input wire logic [1:0] mot_estop_in,
  input wire logic [1:0] mot_fault_in,
  input wire logic [1:0] mot_loop_sel_in,
  input wire logic [1:0] mot_cmd_dir_in,
  input wire logic [1:0] mot_loop_dir_in,
  input wire logic [1:0][15:0] mot_cmd_rate_in,
  input wire logic [1:0][15:0] mot_loop_rate_in,
  // I/O values
  input wire logic [1:0][15:0] ain_milli_in,
  input wire logic [1:0][16:0] fin_deci_in,
  input wire logic [15:0] out_target_milli_in,
  input wire logic [15:0] enc_count_in,
  input wire logic enc_dir_in,
  input wire logic [15:0] vsup_centi_in,
  input wire logic [7:0] temp_c_in,
  // Payload stream
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output logic [15:0] tx_pgn_out,
  output logic [63:0] tx_data_out
);

  dfpe_pkg::dfpe_top_s st_ff;
  dfpe_pkg::dfpe_top_s nxt_st;
  logic [3:0][63:0] fmt;
  logic [3:0][15:0] pgn_tab;
  logic bus_req, bus_first, bus_done, tick, smp_req, trig, start, push;
  logic [3:0] pay_en;

  dfpe_stream_if s_if ();

  // ----------------------------------------------------------------
  // Field formatting
  // ----------------------------------------------------------------

  // One formatter per motor
  for (genvar m = 0; m < 2; m++) begin : g_mot
    dfpe_motor_fmt u_fmt (
      .ph1_ma_in(mot_ph1_ma_in[m]),
      .ph2_ma_in(mot_ph2_ma_in[m]),
      .cmd_mode_in(mot_cmd_mode_in[m]),
      .stepping_in(mot_stepping_in[m]),
      .holding_in(mot_holding_in[m]),
      .estop_in(mot_estop_in[m]),
      .fault_in(mot_fault_in[m]),
      .loop_sel_in(mot_loop_sel_in[m]),
      .cmd_dir_in(mot_cmd_dir_in[m]),
      .loop_dir_in(mot_loop_dir_in[m]),
      .cmd_rate_in(mot_cmd_rate_in[m]),
      .loop_rate_in(mot_loop_rate_in[m]),
      .payload_out(fmt[m])
    );
  end

  // Frequency counts above two bytes saturate
  function automatic logic [15:0] fsat(input logic [16:0] v);
    fsat = v[16] ? dfpe_pkg::FIELD_SAT : v[15:0];
  endfunction

  // I/O payloads, low byte first
  always_comb begin
    fmt[2] = '0;
    fmt[2][dfpe_pkg::IP_AN1 +: 16] = ain_milli_in[0]; // [R8]
    fmt[2][dfpe_pkg::IP_FQ1 +: 16] = fsat(fin_deci_in[0]); // [R9]
    fmt[2][dfpe_pkg::IP_AN2 +: 16] = ain_milli_in[1]; // [R8]
    fmt[2][dfpe_pkg::IP_FQ2 +: 16] = fsat(fin_deci_in[1]); // [R9]
    fmt[3] = '0;
    fmt[3][dfpe_pkg::OP_TGT +: 16] = out_target_milli_in; // [R10] [R16]
    fmt[3][dfpe_pkg::OP_ENC +: 16] = enc_count_in; // [R11]
    fmt[3][dfpe_pkg::OP_EDIR +: 8] = enc_dir_in ? dfpe_pkg::DIR_CW
                                                : dfpe_pkg::DIR_CCW; // [R12]
    fmt[3][dfpe_pkg::OP_VSUP +: 16] = vsup_centi_in; // [R13]
    fmt[3][dfpe_pkg::OP_TEMP +: 8] = temp_c_in; // [R14]
  end

  // Group number per payload slot
  assign pgn_tab[0] = dfpe_pkg::PGN_MOT1; // [R15]
  assign pgn_tab[1] = dfpe_pkg::PGN_MOT2; // [R15]
  assign pgn_tab[2] = dfpe_pkg::PGN_IO1;
  assign pgn_tab[3] = dfpe_pkg::PGN_IO2; // [R16]

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------

  // Bus phases and triggers
  assign bus_req = avs_read_in || avs_write_in;
  assign bus_first = bus_req && st_ff.wreq;
  assign bus_done = bus_req && !st_ff.wreq;
  assign smp_req = bus_done && avs_write_in &&
                   avs_address_in == dfpe_pkg::REG_CTRL &&
                   avs_byteenable_in[0] &&
                   avs_writedata_in[dfpe_pkg::CTRL_SAMPLE_BIT];
  assign tick = st_ff.div >= st_ff.period - 32'h1;
  assign trig = (tick && st_ff.ctrl[dfpe_pkg::CTRL_AUTO_BIT]) || smp_req;
  assign start = st_ff.fsm == dfpe_pkg::FSM_IDLE && (trig || st_ff.pend);
  assign pay_en = st_ff.ctrl[dfpe_pkg::CTRL_EN_LSB +: 4];

  // Stream toward the buffer
  assign s_if.valid = st_ff.fsm == dfpe_pkg::FSM_SEND && pay_en[st_ff.idx];
  assign s_if.pgn = pgn_tab[st_ff.idx];
  assign s_if.data = st_ff.snap[st_ff.idx];
  assign push = s_if.valid && s_if.ready;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // Bus: waitrequest drops for one cycle after the request
    nxt_st.wreq = !bus_first;
    if (bus_first && avs_read_in) begin
      case (avs_address_in)
        dfpe_pkg::REG_CTRL: nxt_st.rdata = {24'h0, st_ff.ctrl};
        dfpe_pkg::REG_PERIOD: nxt_st.rdata = st_ff.period;
        dfpe_pkg::REG_STATUS: begin
          nxt_st.rdata = '0;
          nxt_st.rdata[dfpe_pkg::ST_BUSY_BIT] =
            st_ff.fsm == dfpe_pkg::FSM_SEND;
          nxt_st.rdata[dfpe_pkg::ST_PEND_BIT] = st_ff.pend;
          nxt_st.rdata[dfpe_pkg::ST_FULL_BIT] = !s_if.ready;
          nxt_st.rdata[dfpe_pkg::ST_FRAMES_LSB +: 16] = st_ff.frames;
        end
        default: nxt_st.rdata = '0;
      endcase
    end
    if (bus_done && avs_write_in) begin
      case (avs_address_in)
        dfpe_pkg::REG_CTRL: begin
          if (avs_byteenable_in[0]) begin
            nxt_st.ctrl = avs_writedata_in[7:0];
            nxt_st.ctrl[dfpe_pkg::CTRL_SAMPLE_BIT] = 1'b0;
          end
        end
        dfpe_pkg::REG_PERIOD: begin
          for (int b = 0; b < 4; b++) begin
            if (avs_byteenable_in[b]) begin
              nxt_st.period[8*b +: 8] = avs_writedata_in[8*b +: 8];
            end
          end
        end
        default: ;
      endcase
    end
    // Period divider
    nxt_st.div = tick ? 32'h0 : st_ff.div + 32'h1;
    // Trigger while busy is held, one in the start cycle is absorbed by that start
    if (start) begin
      nxt_st.pend = 1'b0;
    end
    if (trig && !start) begin
      nxt_st.pend = 1'b1;
    end
    // Framing sequence
    case (st_ff.fsm)
      dfpe_pkg::FSM_IDLE: begin
        if (start) begin
          nxt_st.snap = fmt; // [R18]
          nxt_st.idx = 2'h0;
          nxt_st.fsm = dfpe_pkg::FSM_SEND;
        end
      end
      dfpe_pkg::FSM_SEND: begin
        if (!pay_en[st_ff.idx] || s_if.ready) begin
          if (push) begin
            nxt_st.frames = st_ff.frames + 16'h1;
          end
          if (st_ff.idx == 2'h3) begin
            nxt_st.fsm = dfpe_pkg::FSM_IDLE;
          end else begin
            nxt_st.idx = st_ff.idx + 2'h1;
          end
        end
      end
      default: nxt_st.fsm = dfpe_pkg::FSM_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff <= '0;
      st_ff.wreq <= 1'b1;
      st_ff.ctrl <= dfpe_pkg::CTRL_RST;
      st_ff.period <= 32'(PERIOD_CYC);
      st_ff.fsm <= dfpe_pkg::FSM_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avs_waitrequest_out = st_ff.wreq;
  assign avs_readdata_out = st_ff.rdata;

  // Output buffer
  dfpe_tx_buf u_buf (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .in_if(s_if),
    .out_valid_out(tx_valid_out),
    .out_ready_in(tx_ready_in),
    .out_pgn_out(tx_pgn_out),
    .out_data_out(tx_data_out)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  bus_answer_a: assert property (bus_first |=> !avs_waitrequest_out)
    else $error("waitrequest not released");
  phase_one_a: assert property ( // [R1]
    start |=> st_ff.snap[0][15:0] == $past(mot_ph1_ma_in[0]))
    else $error("phase one current not captured");
  phase_two_a: assert property ( // [R2]
    start |=> st_ff.snap[1][31:16] == $past(mot_ph2_ma_in[1]))
    else $error("phase two current not plain value");
  mode_run_a: assert property ( // [R3]
    start && mot_cmd_mode_in[0] == 8'h02 && !mot_estop_in[0] &&
    !mot_fault_in[0] && !mot_holding_in[0] && !mot_stepping_in[0]
    |=> st_ff.snap[0][39:32] == 8'h02)
    else $error("running mode code wrong");
  mode_halt_a: assert property ( // [R4]
    start && (mot_estop_in[1] || mot_fault_in[1])
    |=> st_ff.snap[1][39:32] == 8'h00)
    else $error("halted motor not disabled");
  mot_dir_a: assert property ( // [R5]
    start && mot_loop_sel_in[1] |=> st_ff.snap[1][47:40] ==
    {7'h0, $past(mot_loop_dir_in[1])})
    else $error("motor direction byte wrong");
  cmd_dir_a: assert property ( // [R6]
    start && !mot_loop_sel_in[0] |=> st_ff.snap[0][47:40] ==
    {7'h0, $past(mot_cmd_dir_in[0])})
    else $error("commanded direction not echoed");
  cmd_rate_a: assert property ( // [R7]
    start && !mot_loop_sel_in[0] |=> st_ff.snap[0][63:48] ==
    $past(mot_cmd_rate_in[0]))
    else $error("commanded rate not echoed");
  analog_in_a: assert property ( // [R8]
    start |=> st_ff.snap[2][47:32] == $past(ain_milli_in[1]))
    else $error("analog input field wrong");
  freq_sat_a: assert property ( // [R9]
    start && fin_deci_in[0] > 17'h0ffff |=> st_ff.snap[2][31:16] == 16'hffff)
    else $error("frequency field not saturated");
  out_tgt_a: assert property ( // [R10]
    start |=> st_ff.snap[3][15:0] == $past(out_target_milli_in))
    else $error("output target field wrong");
  enc_count_a: assert property ( // [R11]
    start |=> st_ff.snap[3][31:16] == $past(enc_count_in))
    else $error("encoder count field wrong");
  enc_dir_a: assert property ( // [R12]
    start |=> st_ff.snap[3][39:32] == {7'h0, $past(enc_dir_in)})
    else $error("encoder direction field wrong");
  supply_a: assert property ( // [R13]
    start |=> st_ff.snap[3][55:40] == $past(vsup_centi_in))
    else $error("supply field wrong");
  temp_a: assert property ( // [R14]
    start |=> st_ff.snap[3][63:56] == $past(temp_c_in))
    else $error("temperature field wrong");
  mot_group_a: assert property ( // [R15]
    push && st_ff.idx == 2'h1 |-> s_if.pgn == 16'hff70 &&
    s_if.data == st_ff.snap[1])
    else $error("motor two group wrong");
  io_group_a: assert property ( // [R16]
    push && st_ff.idx == 2'h3 |-> s_if.pgn == 16'hff75)
    else $error("second I/O group wrong");
  byte_order_a: assert property ( // [R17]
    start |=> st_ff.snap[2][7:0] == $past(ain_milli_in[0][7:0]))
    else $error("low byte not first");
  snap_hold_a: assert property ( // [R18]
    st_ff.fsm == dfpe_pkg::FSM_SEND |=> $stable(st_ff.snap))
    else $error("snapshot changed mid sequence");
  stall_hold_a: assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("stalled word lost");

  all_sent_c: cover property (push && st_ff.idx == 2'h3);
  estop_c: cover property (start && mot_estop_in[0]);
  buf_full_c: cover property (!s_if.ready && s_if.valid);
  sample_c: cover property (smp_req ##1 st_ff.fsm == dfpe_pkg::FSM_SEND);

endmodule // dfpe_encoder_top

// File: sim/dfpe_rx_model.sv
// Receiving node model for the payload stream
`timescale 1ns/1ps
module dfpe_rx_model (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Pacing from the bench
  input wire logic slow_in,
  input wire logic hold_in,
  // Payload stream
  input wire logic valid_in,
  input wire logic [15:0] pgn_in,
  input wire logic [63:0] data_in,
  output logic ready_out
);
  logic [15:0] pgn_q[$];
  logic [63:0] data_q[$];
  logic tgl_ff;
  // Stores each accepted word; toggle paces the slow mode
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tgl_ff <= 1'b0;
    end else begin
      tgl_ff <= ~tgl_ff;
      if (valid_in && ready_out) begin
        pgn_q.push_back(pgn_in);
        data_q.push_back(data_in);
      end
    end
  end
  // Ready: stalled by hold, every other cycle when slow
  assign ready_out = ~hold_in & (~slow_in | tgl_ff);
endmodule // dfpe_rx_model

// File: sim/tb.sv
// Self-checking bench for the feedback payload encoder
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [7:0] cmd;
    logic [4:0] fl;
    logic cdir;
    logic ldir;
    logic [7:0] emode;
    logic edir;
    logic [15:0] erate;
  } dfpe_row_s;
  localparam int unsigned PER = 5000;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, q;
  logic wreq, vld, rdy;
  logic [1:0][15:0] ph1 = '0, ph2 = '0, crate = '0, lrate = '0, ain = '0;
  logic [1:0][7:0] cmode = '0;
  logic [1:0] stp = '0, hld = '0, est = '0, flt = '0, lsel = '0;
  logic [1:0] cdir = '0, ldir = '0;
  logic [1:0][16:0] fin = '0;
  logic [15:0] tgt = '0, enc = '0, vsup = '0, pgn;
  logic edir = 1'b0;
  logic [7:0] temp = '0;
  logic slow = 1'b0;
  logic hold = 1'b0;
  logic [63:0] dat;
  int failures = 0;
  int tests_run = 0;
  dfpe_row_s rows [9];
  // Clock, 4 ns period
  initial forever #2 clk = ~clk;
  // Design and receiving node
  dfpe_encoder_top #(.PERIOD_CYC(PER)) uut (
    .clk_sys_in(clk), .rst_b_in(rst_b), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(be),
    .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .mot_ph1_ma_in(ph1),
    .mot_ph2_ma_in(ph2), .mot_cmd_mode_in(cmode),
    .mot_stepping_in(stp), .mot_holding_in(hld), .mot_estop_in(est),
    .mot_fault_in(flt), .mot_loop_sel_in(lsel), .mot_cmd_dir_in(cdir),
    .mot_loop_dir_in(ldir), .mot_cmd_rate_in(crate),
    .mot_loop_rate_in(lrate), .ain_milli_in(ain), .fin_deci_in(fin),
    .out_target_milli_in(tgt), .enc_count_in(enc), .enc_dir_in(edir),
    .vsup_centi_in(vsup), .temp_c_in(temp), .tx_valid_out(vld),
    .tx_ready_in(rdy), .tx_pgn_out(pgn), .tx_data_out(dat));
  dfpe_rx_model rx (
    .clk_sys_in(clk), .rst_b_in(rst_b), .slow_in(slow), .hold_in(hold),
    .valid_in(vld), .pgn_in(pgn), .data_in(dat), .ready_out(rdy));
  // Verdict and end of run
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string nm, input logic [63:0] got,
                     input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One register access, held until waitrequest samples low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    addr <= a;
    wd <= d;
    be <= (a == 8'h00) ? 4'h1 : 4'hf;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wreq !== 1'b0) begin
      failures++;
      wrap_up();
    end
    @(posedge clk);
  endtask
  // Wait for n received words, bounded
  task automatic get(input int n);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rx.pgn_q.size() < n && k < 200);
    if (rx.pgn_q.size() < n) begin
      failures++;
      wrap_up();
    end
  endtask
  // Apply one row to both motors and the I/O values
  task automatic drive(input dfpe_row_s r, input int i);
    for (int m = 0; m < 2; m++) begin
      ph1[m] <= 16'h1000 + 16'(i + m);
      ph2[m] <= 16'h2000 + 16'(i + m);
      {stp[m], hld[m], est[m], flt[m], lsel[m]} <= r.fl;
      cmode[m] <= r.cmd;
      cdir[m] <= r.cdir;
      ldir[m] <= r.ldir;
      crate[m] <= 16'h1234;
      lrate[m] <= 16'h0abc;
    end
    ain <= {16'h4e20, 16'h2710};
    fin <= {17'(i), (i == 0) ? 17'h186a0 : 17'h003e8};
    tgt <= 16'h2710;
    enc <= 16'hfffe - 16'(i);
    edir <= 1'(i);
    vsup <= 16'h0960 + 16'(i);
    temp <= 8'hf6;
  endtask
  // Pop and compare the four payloads of one sequence
  task automatic expect4(input dfpe_row_s r, input int i);
    logic [63:0] e [4];
    logic [15:0] g [4];
    g = '{16'hff50, 16'hff70, 16'hff55, 16'hff75};
    for (int m = 0; m < 2; m++) begin
      e[m] = {r.erate, 7'h00, r.edir, r.emode, 16'h2000 + 16'(i + m),
              16'h1000 + 16'(i + m)};
    end
    e[2] = {16'(i), 16'h4e20, (i == 0) ? 16'hffff : 16'h03e8, 16'h2710};
    e[3] = {8'hf6, 16'h0960 + 16'(i), 7'h00, 1'(i), 16'hfffe - 16'(i),
            16'h2710};
    for (int k = 0; k < 4; k++) begin
      chk("pgn", {48'h0, rx.pgn_q.pop_front()}, {48'h0, g[k]});
      chk("data", rx.data_q.pop_front(), e[k]);
    end
  endtask
  // Main sequence
  initial begin
    rows = '{'{8'h00, 5'h00, 1'b1, 1'b0, 8'h00, 1'b1, 16'h1234},
             '{8'h01, 5'h00, 1'b0, 1'b1, 8'h01, 1'b0, 16'h1234},
             '{8'h02, 5'h00, 1'b1, 1'b0, 8'h02, 1'b1, 16'h1234},
             '{8'h02, 5'h10, 1'b0, 1'b0, 8'h03, 1'b0, 16'h1234},
             '{8'h02, 5'h08, 1'b1, 1'b1, 8'h04, 1'b1, 16'h1234},
             '{8'h03, 5'h18, 1'b0, 1'b0, 8'h04, 1'b0, 16'h1234},
             '{8'h02, 5'h04, 1'b1, 1'b0, 8'h00, 1'b1, 16'h1234},
             '{8'h04, 5'h02, 1'b0, 1'b0, 8'h00, 1'b0, 16'h1234},
             '{8'h04, 5'h01, 1'b0, 1'b1, 8'h04, 1'b1, 16'h0abc}};
    repeat (2) @(posedge clk);
    chk("reset valid", {63'h0, vld}, 64'h0);
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(1'b0, 8'h00, 32'h0, q);
    chk("ctrl", {32'h0, q}, 64'hf1);
    bus(1'b0, 8'h04, 32'h0, q);
    chk("period", {32'h0, q}, 64'(PER));
    bus(1'b1, 8'h0c, 32'hffffffff, q);
    bus(1'b0, 8'h0c, 32'h0, q);
    chk("unmapped", {32'h0, q}, 64'h0);
    // Rows: sample now, then disturb inputs while the frames go out
    for (int i = 0; i < 9; i++) begin
      drive(rows[i], i);
      slow <= 1'(i);
      @(posedge clk);
      bus(1'b1, 8'h00, 32'hf2, q);
      ph1 <= '1;
      ain <= '0;
      enc <= 16'h0000;
      temp <= 8'h00;
      crate <= '0;
      get(4);
      expect4(rows[i], i);
      $display("row %0d done", i);
    end
    // Stalled receiver: buffer fills, second trigger pends
    drive(rows[0], 0);
    hold <= 1'b1;
    @(posedge clk);
    bus(1'b1, 8'h00, 32'hf2, q);
    repeat (6) @(posedge clk);
    bus(1'b0, 8'h08, 32'h0, q);
    chk("busy full", {61'h0, q[2:0]}, 64'h5);
    bus(1'b1, 8'h00, 32'hf2, q);
    bus(1'b0, 8'h08, 32'h0, q);
    chk("pending", {61'h0, q[2:0]}, 64'h7);
    hold <= 1'b0;
    slow <= 1'b1;
    get(8);
    expect4(rows[0], 0);
    expect4(rows[0], 0);
    $display("stall test done");
    // Only slots 0 and 2 enabled
    slow <= 1'b0;
    @(posedge clk);
    bus(1'b1, 8'h00, 32'h52, q);
    get(2);
    repeat (8) @(posedge clk);
    chk("count", 64'(rx.pgn_q.size()), 64'h2);
    chk("slot0", {48'h0, rx.pgn_q.pop_front()}, 64'hff50);
    chk("slot2", {48'h0, rx.pgn_q.pop_front()}, 64'hff55);
    rx.data_q.delete();
    bus(1'b0, 8'h08, 32'h0, q);
    chk("frames", {48'h0, q[31:16]}, 64'h2e);
    $display("slot test done");
    wrap_up();
  end
endmodule // tb
